// file: dhsi_pkg.sv
// constants and types for the dac host serial interface
// Notes on behaviour
// - queue enable level is sampled after power-up, reset sequence and clear
// - queue only in parallel mode, 128 entries, writes dropped when full
// - reset sequence restores registers, holds busy low, refuses writes
// - busy low while queued writes execute; new writes still accepted
// - global power-down leaves every stored register untouched
// - port select picks parallel or serial; protocol pin picks spi or i2c
// - interface wakes fully only on falling write strobe or frame sync
// - frame msb first: bank, read/write, channel, destination, 14-bit data
// - stand-alone: sync fall starts frame; clock ignored after 24 bits
// - chain mode: bits beyond 24 shift out, change on rising clock
// - host gives 24 clocks per device; sync rise latches, stops shifting
// - sync rising before 24 clocks discards the frame
// - read frame selects register; its value returns in next frame
// - readback frame: value in 14 data bits, upper 10 echo address
// - readback shifts on rising clock; first bit ready at sync fall
// - i2c slave only, never drives clock, up to 400 khz
// - i2c address: 5 fixed upper bits, low 2 from strap pins
// - during reset sequence all host ports and load pulses are ignored
package dhsi_pkg;
  localparam int FRAME_BITS = 24;
  localparam int QUEUE_DEPTH = 128;
  localparam int QPTR_W = 7;
  localparam int QCNT_W = 8;
  localparam int ENTRY_W = 23;
  localparam int BANK_POS = 23;
  localparam int RW_POS = 22;
  localparam int CHAN_LSB = 16;
  localparam int CHAN_W = 6;
  localparam int DEST_LSB = 14;
  localparam int DEST_W = 2;
  localparam int DATA_W = 14;
  localparam int ECHO_W = 10;
  localparam int CLK_PERIOD_NS = 40;
  localparam int RESET_TIME_NS = 300000;
  localparam int RESET_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_IDLE_CYCLES = 16;
  // arbitrary value, upper five bits of the i2c slave address
  localparam logic [4:0] I2C_ADDR_FIXED = 5'h0b;
  typedef enum {IIC_IDLE, IIC_ADDR, IIC_DATA, IIC_ACK, IIC_SKIP} dhsi_iic_state_type;
  typedef enum {DR_IDLE, DR_READ} dhsi_drain_state_type;
endpackage : dhsi_pkg

// file: dhsi_queue_mem.sv
// write queue storage with registered read data
`timescale 1ns/1ps
module dhsi_queue_mem (
  input wire logic sys_clk_i,
  input wire logic wr_en_i,
  input wire logic [dhsi_pkg::QPTR_W-1:0] wr_addr_i,
  input wire logic [dhsi_pkg::ENTRY_W-1:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic [dhsi_pkg::QPTR_W-1:0] rd_addr_i,
  output logic [dhsi_pkg::ENTRY_W-1:0] rd_data_o
);
  logic [dhsi_pkg::ENTRY_W-1:0] mem [0:dhsi_pkg::QUEUE_DEPTH-1];

  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    if (rd_en_i) begin
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule : dhsi_queue_mem

// file: dhsi_serial_link.sv
// serial shift register on the link clock
`timescale 1ns/1ps
module dhsi_serial_link (
  input wire logic link_sclk_i,
  input wire logic rst_n_i,
  input wire logic sync_n_i,
  input wire logic din_i,
  input wire logic chain_enable_i,
  input wire logic [dhsi_pkg::FRAME_BITS-1:0] load_word_i,
  output logic [dhsi_pkg::FRAME_BITS-1:0] frame_word_o,
  output logic [4:0] bit_count_o,
  output logic chain_data_out_o
);
  logic [1:0] chain_meta;
  logic in_frame;

  always_ff @(negedge link_sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chain_meta <= 2'h0;
    end else begin
      chain_meta <= {chain_meta[0], chain_enable_i};
    end
  end

  // frame flag ends with the frame's own sync, no clock needed
  always_ff @(negedge link_sclk_i or posedge sync_n_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_frame <= 1'b0;
    end else if (sync_n_i) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  // word and count hold still while sync is high
  always_ff @(negedge link_sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_word_o <= 24'h000000;
      bit_count_o <= 5'h00;
    end else if (!sync_n_i) begin
      if (!in_frame) begin
        frame_word_o <= {load_word_i[22:0], din_i};
        bit_count_o <= 5'h01;
      end else if (bit_count_o < 5'(dhsi_pkg::FRAME_BITS) || chain_meta[1]) begin
        frame_word_o <= {frame_word_o[22:0], din_i};
        if (bit_count_o < 5'(dhsi_pkg::FRAME_BITS)) begin
          bit_count_o <= bit_count_o + 5'h01;
        end
      end
    end
  end

  // sync fall shows the first bit while sclk idles high
  always_ff @(posedge link_sclk_i or negedge sync_n_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chain_data_out_o <= 1'b0;
    end else if (!in_frame) begin
      chain_data_out_o <= load_word_i[23];
    end else begin
      chain_data_out_o <= frame_word_o[23];
    end
  end
endmodule : dhsi_serial_link

// file: dhsi_host_iface.sv
// host port selection, write queue, busy and serial/i2c frame handling
`timescale 1ns/1ps
module dhsi_host_iface #(
  parameter int RESET_CYCLES = dhsi_pkg::RESET_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic link_sclk_i,
  input wire logic sync_n_i,
  input wire logic din_i,
  input wire logic host_port_select_i,
  input wire logic protocol_select_i,
  input wire logic chain_enable_i,
  input wire logic queue_enable_i,
  input wire logic reset_pin_n_i,
  input wire logic clear_n_i,
  input wire logic load_outputs_n_i,
  input wire logic wr_n_i,
  input wire logic cs_n_i,
  input wire logic [5:0] channel_address_i,
  input wire logic dest_select_high_i,
  input wire logic dest_select_low_i,
  input wire logic [13:0] data_word_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic addr_strap_high_i,
  input wire logic addr_strap_low_i,
  input wire logic reg_ready_i,
  input wire logic [13:0] rd_data_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic chain_data_out_o,
  output logic busy_n_o,
  output logic regs_restore_o,
  output logic clear_o,
  output logic dac_update_o,
  output logic iface_awake_o,
  output logic reg_wr_o,
  output logic reg_bank_o,
  output logic [5:0] reg_chan_o,
  output logic [1:0] reg_dest_o,
  output logic [13:0] reg_data_o,
  output logic rd_req_o,
  output logic [5:0] rd_chan_o,
  output logic [1:0] rd_dest_o
);
  localparam int PIN_W = 35;
  localparam logic [12:0] RST_LOAD = 13'(RESET_CYCLES);

  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic [5:0] pin_prev;
  logic s_wr_n, s_cs_n, s_sync_n, s_scl, s_sda, s_hps, s_proto, s_qen, s_rst_n, s_clr_n, s_load_outputs_n_n;
  logic s_strap_hi, s_strap_lo;
  logic [5:0] s_chan;
  logic [1:0] s_dest;
  logic [13:0] s_data;
  logic wr_rise, wr_fall, sync_rise, sync_fall, scl_rise, scl_fall, iic_start, iic_stop, rst_fall, clr_fall;
  logic par_mode, spi_mode, iic_mode;
  logic [12:0] rst_cnt;
  logic resetting;
  logic queue_on;
  logic [dhsi_pkg::QCNT_W-1:0] q_count;
  logic [dhsi_pkg::QPTR_W-1:0] wr_ptr, rd_ptr;
  logic q_full, push, pop;
  logic [dhsi_pkg::ENTRY_W-1:0] push_entry, q_rd_data;
  dhsi_pkg::dhsi_drain_state_type drain;
  logic [dhsi_pkg::FRAME_BITS-1:0] link_word, out_word;
  logic [4:0] link_count;
  logic serial_ok, rb_pending;
  logic [dhsi_pkg::ECHO_W-1:0] rb_echo;
  dhsi_pkg::dhsi_iic_state_type iic_state;
  logic [3:0] iic_bits;
  logic [7:0] iic_shift, iic_ptr, iic_hi;
  logic [1:0] iic_byte;
  logic iic_push;
  logic idle, idle_prev, load_outputs_n_pend, load_outputs_n_fire, load_outputs_n_prev;
  logic [4:0] wake_cnt;

  // every pin except reg_ready_i, rd_data_i, link_sclk_i, din_i and chain_enable_i passes two flops here before use
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta <= 35'h7ffffffff;
      pin_sync <= 35'h7ffffffff;
      pin_prev <= 6'h3f;
      load_outputs_n_prev <= 1'b1;
    end else begin
      pin_meta <= {wr_n_i, cs_n_i, sync_n_i, scl_i, sda_i, host_port_select_i, protocol_select_i,
                   queue_enable_i, reset_pin_n_i, clear_n_i, load_outputs_n_i, addr_strap_high_i,
                   addr_strap_low_i, channel_address_i, dest_select_high_i, dest_select_low_i, data_word_i};
      pin_sync <= pin_meta;
      pin_prev <= {s_wr_n, s_sync_n, s_scl, s_sda, s_rst_n, s_clr_n};
      load_outputs_n_prev <= s_load_outputs_n_n;
    end
  end

  assign {s_wr_n, s_cs_n, s_sync_n, s_scl, s_sda, s_hps, s_proto, s_qen, s_rst_n, s_clr_n, s_load_outputs_n_n,
          s_strap_hi, s_strap_lo, s_chan, s_dest, s_data} = pin_sync;
  assign wr_rise = s_wr_n && !pin_prev[5];
  assign wr_fall = !s_wr_n && pin_prev[5];
  assign sync_rise = s_sync_n && !pin_prev[4];
  assign sync_fall = !s_sync_n && pin_prev[4];
  assign scl_rise = s_scl && !pin_prev[3];
  assign scl_fall = !s_scl && pin_prev[3];
  assign iic_start = s_scl && pin_prev[3] && !s_sda && pin_prev[2];
  assign iic_stop = s_scl && pin_prev[3] && s_sda && !pin_prev[2];
  assign rst_fall = !s_rst_n && pin_prev[1];
  assign clr_fall = !s_clr_n && pin_prev[0];

  assign par_mode = !s_hps;
  assign spi_mode = s_hps && s_proto;
  assign iic_mode = s_hps && !s_proto;

  // reset sequence runs after power-up and on each reset pin fall outside a running sequence
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_cnt <= RST_LOAD;
    end else if (rst_fall && !resetting) begin
      rst_cnt <= RST_LOAD;
    end else if (resetting) begin
      rst_cnt <= rst_cnt - 13'h0001;
    end
  end
  assign resetting = rst_cnt != 13'h0000;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      queue_on <= 1'b0;
      regs_restore_o <= 1'b1;
      clear_o <= 1'b0;
    end else begin
      regs_restore_o <= resetting;
      clear_o <= clr_fall && !resetting;
      if ((rst_cnt == 13'h0001) || (clr_fall && !resetting)) begin
        queue_on <= s_qen;
      end
    end
  end

  // queue limit is one entry when the queue is off or not in parallel mode
  assign q_full = (queue_on && par_mode) ? (q_count >= 8'(dhsi_pkg::QUEUE_DEPTH)) : (q_count != 8'h00);
  assign serial_ok = spi_mode && !resetting && sync_rise && (link_count == 5'(dhsi_pkg::FRAME_BITS));

  always_comb begin
    push = 1'b0;
    push_entry = '0;
    if (par_mode && wr_rise && !s_cs_n) begin
      push = 1'b1;
      push_entry = {1'b0, s_chan, s_dest, s_data};
    end else if (serial_ok && !link_word[dhsi_pkg::RW_POS] && link_word != 24'h000000) begin
      push = 1'b1;
      push_entry = {link_word[dhsi_pkg::BANK_POS], link_word[21:0]};
    end else if (iic_push) begin
      push = 1'b1;
      push_entry = {1'b0, iic_ptr[5:0], iic_hi[7:6], iic_hi[5:0], iic_shift};
    end
    push = push && !q_full && !resetting;
  end
  assign pop = (drain == dhsi_pkg::DR_IDLE) && (q_count != 8'h00) && reg_ready_i && !resetting;

  // only the reset sequence empties the queue; power-down never reaches it
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_count <= 8'h00;
      wr_ptr <= 7'h00;
      rd_ptr <= 7'h00;
      drain <= dhsi_pkg::DR_IDLE;
    end else if (resetting) begin
      q_count <= 8'h00;
      wr_ptr <= 7'h00;
      rd_ptr <= 7'h00;
      drain <= dhsi_pkg::DR_IDLE;
    end else begin
      q_count <= q_count + 8'(push) - 8'(pop);
      if (push) begin
        wr_ptr <= wr_ptr + 7'h01;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 7'h01;
      end
      case (drain)
        dhsi_pkg::DR_IDLE: drain <= pop ? dhsi_pkg::DR_READ : dhsi_pkg::DR_IDLE;
        dhsi_pkg::DR_READ: drain <= dhsi_pkg::DR_IDLE;
        default: drain <= dhsi_pkg::DR_IDLE;
      endcase
    end
  end

  dhsi_queue_mem u_queue_mem (
    .sys_clk_i(sys_clk_i),
    .wr_en_i(push),
    .wr_addr_i(wr_ptr),
    .wr_data_i(push_entry),
    .rd_en_i(pop),
    .rd_addr_i(rd_ptr),
    .rd_data_o(q_rd_data)
  );

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_wr_o <= 1'b0;
      reg_bank_o <= 1'b0;
      reg_chan_o <= 6'h00;
      reg_dest_o <= 2'h0;
      reg_data_o <= 14'h0000;
    end else begin
      reg_wr_o <= (drain == dhsi_pkg::DR_READ) && !resetting;
      if (drain == dhsi_pkg::DR_READ) begin
        reg_bank_o <= q_rd_data[22];
        reg_chan_o <= q_rd_data[21:16];
        reg_dest_o <= q_rd_data[15:14];
        reg_data_o <= q_rd_data[13:0];
      end
    end
  end

  // busy low through reset sequence and while queue entries remain
  assign idle = !resetting && (q_count == 8'h00) && (drain == dhsi_pkg::DR_IDLE);
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_n_o <= 1'b0;
      idle_prev <= 1'b0;
    end else begin
      busy_n_o <= idle;
      idle_prev <= idle;
    end
  end

  // load pulse stored while busy, dropped during reset sequence
  assign load_outputs_n_fire = idle && (load_outputs_n_pend || (!s_load_outputs_n_n && (!idle_prev || load_outputs_n_prev)));
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      load_outputs_n_pend <= 1'b0;
      dac_update_o <= 1'b0;
    end else if (resetting) begin
      load_outputs_n_pend <= 1'b0;
      dac_update_o <= 1'b0;
    end else begin
      dac_update_o <= load_outputs_n_fire;
      if (!s_load_outputs_n_n && !idle) begin
        load_outputs_n_pend <= 1'b1;
      end else if (load_outputs_n_fire) begin
        load_outputs_n_pend <= 1'b0;
      end
    end
  end

  dhsi_serial_link u_serial_link (
    .link_sclk_i(link_sclk_i),
    .rst_n_i(rst_n_i),
    .sync_n_i(sync_n_i),
    .din_i(din_i),
    .chain_enable_i(chain_enable_i),
    .load_word_i(out_word),
    .frame_word_o(link_word),
    .bit_count_o(link_count),
    .chain_data_out_o(chain_data_out_o)
  );

  // out_word only changes just after sync rise, while the link is idle
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_req_o <= 1'b0;
      rd_chan_o <= 6'h00;
      rd_dest_o <= 2'h0;
      rb_pending <= 1'b0;
      rb_echo <= 10'h000;
      out_word <= 24'h000000;
    end else begin
      rd_req_o <= 1'b0;
      rb_pending <= 1'b0;
      if (serial_ok && link_word[dhsi_pkg::RW_POS]) begin
        rd_req_o <= 1'b1;
        rd_chan_o <= link_word[21:16];
        rd_dest_o <= link_word[15:14];
        rb_echo <= link_word[23:14];
        rb_pending <= 1'b1;
      end else if (serial_ok || (spi_mode && sync_rise && !resetting)) begin
        out_word <= 24'h000000;
      end
      if (rb_pending) begin
        out_word <= {rb_echo, rd_data_i};
      end
    end
  end

  // i2c slave receiver: address, then pointer and two data bytes repeating
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      iic_state <= dhsi_pkg::IIC_IDLE;
      iic_bits <= 4'h0;
      iic_shift <= 8'h00;
      iic_ptr <= 8'h00;
      iic_hi <= 8'h00;
      iic_byte <= 2'h0;
      iic_push <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (!iic_mode || resetting || iic_stop) begin
      iic_state <= dhsi_pkg::IIC_IDLE;
      iic_push <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (iic_start) begin
      iic_state <= dhsi_pkg::IIC_ADDR;
      iic_bits <= 4'h0;
      iic_byte <= 2'h0;
      iic_push <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      iic_push <= 1'b0;
      case (iic_state)
        dhsi_pkg::IIC_ADDR, dhsi_pkg::IIC_DATA: begin
          if (scl_rise) begin
            iic_shift <= {iic_shift[6:0], s_sda};
            iic_bits <= iic_bits + 4'h1;
          end else if (scl_fall && iic_bits == 4'h8) begin
            if (iic_state == dhsi_pkg::IIC_ADDR && iic_shift != {dhsi_pkg::I2C_ADDR_FIXED, s_strap_hi, s_strap_lo, 1'b0}) begin
              iic_state <= dhsi_pkg::IIC_SKIP;
            end else begin
              sda_oe_o <= 1'b1;
              iic_state <= dhsi_pkg::IIC_ACK;
            end
          end
        end
        dhsi_pkg::IIC_ACK: begin
          if (scl_fall) begin
            sda_oe_o <= 1'b0;
            iic_state <= dhsi_pkg::IIC_DATA;
            iic_bits <= 4'h0;
            if (iic_byte == 2'h1) begin
              iic_ptr <= iic_shift;
            end else if (iic_byte == 2'h2) begin
              iic_hi <= iic_shift;
            end
            iic_push <= iic_byte == 2'h3;
            iic_byte <= (iic_byte == 2'h3) ? 2'h1 : iic_byte + 2'h1;
          end
        end
        dhsi_pkg::IIC_SKIP, dhsi_pkg::IIC_IDLE: iic_bits <= 4'h0;
        default: iic_state <= dhsi_pkg::IIC_IDLE;
      endcase
    end
  end
  assign sda_o = 1'b0;

  // interface stays in low power until a strobe or sync falls
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      iface_awake_o <= 1'b0;
      wake_cnt <= 5'h00;
    end else if ((wr_fall && par_mode) || (sync_fall && spi_mode)) begin
      iface_awake_o <= !resetting;
      wake_cnt <= 5'(dhsi_pkg::WAKE_IDLE_CYCLES);
    end else if (idle && s_wr_n && s_sync_n && wake_cnt != 5'h00) begin
      wake_cnt <= wake_cnt - 5'h01;
      iface_awake_o <= wake_cnt != 5'h01;
    end
  end
endmodule : dhsi_host_iface

// file: dhsi_host_iface_chk.sv
// assertion checker for the dac host serial interface
`timescale 1ns/1ps
module dhsi_host_iface_chk #(
  parameter int RESET_CYCLES = 20
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic host_port_select_i,
  input wire logic busy_n_o,
  input wire logic regs_restore_o,
  input wire logic dac_update_o,
  input wire logic reg_wr_o,
  input wire logic reg_bank_o,
  input wire logic [5:0] reg_chan_o,
  input wire logic [1:0] reg_dest_o,
  input wire logic [13:0] reg_data_o,
  input wire logic rd_req_o,
  input wire logic [5:0] rd_chan_o,
  input wire logic [1:0] rd_dest_o,
  input wire logic sda_o,
  input wire logic sda_oe_o
);
  int unsigned restore_len;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // cycles spent in the current restore sequence
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      restore_len <= 0;
    end else if (regs_restore_o) begin
      restore_len <= restore_len + 1;
    end else begin
      restore_len <= 0;
    end
  end
  AST_RESTORE_BUSY: assert property (regs_restore_o |-> !busy_n_o)
    else $error("busy released during restore");
  AST_RESTORE_QUIET: assert property (regs_restore_o |-> !(reg_wr_o || rd_req_o || dac_update_o))
    else $error("activity during restore");
  AST_RESTORE_MAX: assert property (restore_len <= RESET_CYCLES + 3)
    else $error("restore too long");
  AST_RESTORE_MIN: assert property ($fell(regs_restore_o) |-> restore_len >= RESET_CYCLES - 1)
    else $error("restore too short");
  AST_BUSY_RETURNS: assert property ($fell(regs_restore_o) |-> ##[0:3] busy_n_o)
    else $error("busy stuck after restore");
  AST_SDA_LOW: assert property (!sda_o && !(regs_restore_o && sda_oe_o))
    else $error("sda driven high or during restore");
  AST_NO_ACK_PAR: assert property ((!host_port_select_i)[*4] |-> !sda_oe_o)
    else $error("ack in parallel mode");
  AST_NO_RD_PAR: assert property ((!host_port_select_i)[*4] |-> !rd_req_o)
    else $error("read request in parallel mode");
  AST_RD_HELD: assert property (!rd_req_o |-> $stable({rd_chan_o, rd_dest_o}))
    else $error("read select changed");
  AST_WR_HELD: assert property (!reg_wr_o |-> $stable({reg_bank_o, reg_chan_o, reg_dest_o, reg_data_o}))
    else $error("write fields changed");
endmodule : dhsi_host_iface_chk

bind dhsi_host_iface dhsi_host_iface_chk #(.RESET_CYCLES(RESET_CYCLES)) u_chk (.*);

// file: dhsi_host_model.sv
// host serial master model driving frames on the link
`timescale 1ns/1ps
module dhsi_host_model (
  output logic sclk_o,
  output logic sync_n_o,
  output logic din_o,
  input wire logic sdo_i
);
  logic [47:0] got;
  initial begin
    sclk_o = 1'b1;
    sync_n_o = 1'b1;
    din_o = 1'b0;
    got = 48'h0;
  end
  // msb first, exact burst of n clocks, clock idles high
  task automatic send(input logic [47:0] w, input int n);
    got = 48'h0;
    #7 sync_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      din_o = w[i];
      #32 sclk_o = 1'b0;
      got = {got[46:0], sdo_i};
      #32 sclk_o = 1'b1;
    end
    #20 sync_n_o = 1'b1;
    din_o = ~din_o;
    #600;
  endtask : send
endmodule : dhsi_host_model

// file: dac_host_serial_interface_test.sv
// testbench for the dac host serial interface
`timescale 1ns/1ps
module dac_host_serial_interface_test;
  localparam int RST_CYC = 20;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, sync_n_i, din_i, link_sclk_i;
  logic host_port_select_i = 1'b1, protocol_select_i = 1'b1, chain_enable_i = 1'b0, queue_enable_i = 1'b1;
  logic reset_pin_n_i = 1'b1, clear_n_i = 1'b1, load_outputs_n_i = 1'b1, wr_n_i = 1'b1, cs_n_i = 1'b1;
  logic dest_select_high_i = 1'b0, dest_select_low_i = 1'b0, scl_i = 1'b1, sda_i = 1'b1, reg_ready_i = 1'b1;
  logic addr_strap_high_i = 1'b0, addr_strap_low_i = 1'b1;
  logic [5:0] channel_address_i = 6'h00, rd_chan_o, reg_chan_o;
  logic [13:0] data_word_i = 14'h0000, rd_data_i = 14'h2a5c, reg_data_o;
  logic [1:0] reg_dest_o, rd_dest_o;
  logic sda_o, sda_oe_o, chain_data_out_o, busy_n_o, regs_restore_o, clear_o, dac_update_o, iface_awake_o;
  logic reg_wr_o, reg_bank_o, rd_req_o;
  int fail_count = 0, comparisons = 0, cyc = 0, wr_cnt = 0, rd_cnt = 0, clr_cnt = 0, upd_cnt = 0;

  dhsi_host_iface #(.RESET_CYCLES(RST_CYC)) DUT (.*);
  dhsi_host_model host (.sclk_o(link_sclk_i), .sync_n_o(sync_n_i), .din_o(din_i), .sdo_i(chain_data_out_o));

  always #20 sys_clk_i = ~sys_clk_i;

  always @(posedge sys_clk_i) begin
    cyc++;
    wr_cnt += (reg_wr_o === 1'b1);
    rd_cnt += (rd_req_o === 1'b1);
    clr_cnt += (clear_o === 1'b1);
    upd_cnt += (dac_update_o === 1'b1);
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tick

  task automatic await_wr(input int c, input int lim);
    for (int i = 0; i < lim && wr_cnt == c; i++) tick(1);
  endtask : await_wr

  task automatic pwrite(input int n);
    for (int i = 0; i < n; i++) begin
      cs_n_i = 1'b0;
      channel_address_i = i[5:0];
      data_word_i = i[13:0];
      {dest_select_high_i, dest_select_low_i} = i[1:0];
      wr_n_i = 1'b0;
      tick(2);
      wr_n_i = 1'b1;
      tick(3);
      cs_n_i = 1'b1;
      tick(1);
    end
  endtask : pwrite

  task automatic i2c_cond(input logic from, input logic to);
    sda_i = from;
    tick(4);
    scl_i = 1'b1;
    tick(4);
    sda_i = to;
    tick(4);
    scl_i = to;
  endtask : i2c_cond

  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_i = b[i];
      tick(4);
      scl_i = 1'b1;
      tick(4);
      scl_i = 1'b0;
    end
    sda_i = 1'b1;
    tick(4);
    scl_i = 1'b1;
    tick(2);
    ack = sda_oe_o;
    tick(2);
    scl_i = 1'b0;
  endtask : i2c_byte

  task automatic t_i2c();
    int c;
    logic [3:0] a;
    host_port_select_i = 1'b1;
    protocol_select_i = 1'b0;
    tick(4);
    c = wr_cnt;
    i2c_cond(1'b1, 1'b0);
    i2c_byte({dhsi_pkg::I2C_ADDR_FIXED, addr_strap_high_i, addr_strap_low_i, 1'b0}, a[3]);
    i2c_byte(8'h25, a[2]);
    i2c_byte(8'h9a, a[1]);
    i2c_byte(8'h3c, a[0]);
    i2c_cond(1'b0, 1'b1);
    await_wr(c, 30);
    check("iic_ack", a, 32'hf);
    check("iic_wr", wr_cnt - c, 32'h1);
    check("iic_fields", {reg_bank_o, reg_chan_o, reg_dest_o, reg_data_o}, {1'b0, 6'h25, 2'b10, 14'h1a3c});
    i2c_cond(1'b1, 1'b0);
    i2c_byte({dhsi_pkg::I2C_ADDR_FIXED, !addr_strap_high_i, addr_strap_low_i, 1'b0}, a[3]);
    i2c_cond(1'b0, 1'b1);
    check("iic_nack", a[3], 32'h0);
  endtask : t_i2c

  task automatic t_reset();
    int u;
    tick(8);
    rst_n_i = 1'b1;
    tick(2);
    check("busy_rst", busy_n_o, 32'h0);
    u = upd_cnt;
    load_outputs_n_i = 1'b0;
    tick(3);
    load_outputs_n_i = 1'b1;
    for (int i = 0; i < 60 && busy_n_o !== 1'b1; i++) tick(1);
    tick(10);
    check("busy_end", busy_n_o, 32'h1);
    check("load_outputs_n_rst", upd_cnt - u, 32'h0);
    load_outputs_n_i = 1'b0;
    tick(3);
    load_outputs_n_i = 1'b1;
    tick(4);
    check("load_outputs_n_idle", upd_cnt - u, 32'h1);
    reset_pin_n_i = 1'b0;
    tick(4);
    check("restore_pin", {regs_restore_o, busy_n_o}, 32'h2);
    reset_pin_n_i = 1'b1;
    for (int i = 0; i < 60 && busy_n_o !== 1'b1; i++) tick(1);
    check("busy_pin", busy_n_o, 32'h1);
  endtask : t_reset

  task automatic t_serial();
    int c;
    logic [23:0] w;
    w = {1'b1, 1'b0, 6'h15, 2'b10, 14'h1abc};
    tick(40);
    check("asleep", iface_awake_o, 32'h0);
    c = wr_cnt;
    fork
      host.send({24'h0, w}, 24);
      begin
        tick(12);
        check("awake", iface_awake_o, 32'h1);
      end
    join
    await_wr(c, 30);
    check("wr", wr_cnt - c, 32'h1);
    check("fields", {reg_bank_o, reg_chan_o, reg_dest_o, reg_data_o}, {w[23], w[21:0]});
  endtask : t_serial

  task automatic t_frames();
    int c;
    logic [23:0] w;
    w = {1'b0, 1'b0, 6'h2a, 2'b01, 14'h0f0f};
    c = wr_cnt;
    host.send({24'h0, w}, 23);
    tick(10);
    check("short", wr_cnt - c, 32'h0);
    host.send({22'h0, w, 2'b11}, 26);
    await_wr(c, 30);
    check("over_cnt", wr_cnt - c, 32'h1);
    check("over", {reg_bank_o, reg_chan_o, reg_dest_o, reg_data_o}, {w[23], w[21:0]});
  endtask : t_frames

  task automatic t_readback();
    int c;
    int r;
    logic [23:0] w;
    w = {1'b0, 1'b1, 6'h07, 2'b01, 14'h0000};
    c = wr_cnt;
    r = rd_cnt;
    host.send({24'h0, w}, 24);
    check("rd_req", rd_cnt - r, 32'h1);
    check("rd_sel", {rd_chan_o, rd_dest_o}, {6'h07, 2'b01});
    host.send(48'h0, 24);
    check("readback", host.got[23:0], {w[23:14], rd_data_i});
    check("no_wr", wr_cnt - c, 32'h0);
  endtask : t_readback

  task automatic t_chain();
    int c;
    logic [23:0] a;
    logic [23:0] b;
    a = {1'b0, 1'b0, 6'h11, 2'b00, 14'h0555};
    b = {1'b1, 1'b0, 6'h22, 2'b11, 14'h2aaa};
    chain_enable_i = 1'b1;
    tick(4);
    c = wr_cnt;
    host.send({a, b}, 48);
    await_wr(c, 30);
    check("chain_out", host.got[23:0], a);
    check("chain_cnt", wr_cnt - c, 32'h1);
    check("chain_latch", {reg_bank_o, reg_chan_o, reg_dest_o, reg_data_o}, {b[23], b[21:0]});
    chain_enable_i = 1'b0;
  endtask : t_chain

  task automatic t_fill();
    int c;
    host_port_select_i = 1'b0;
    reg_ready_i = 1'b0;
    tick(4);
    c = wr_cnt;
    pwrite(130);
    tick(4);
    check("busy_q", busy_n_o, 32'h0);
    reg_ready_i = 1'b1;
    for (int i = 0; i < 2000 && busy_n_o !== 1'b1; i++) tick(1);
    tick(4);
    check("drained", wr_cnt - c, 32'h80);
    check("last", reg_data_o, 32'h7f);
  endtask : t_fill

  task automatic t_clear();
    int c;
    c = clr_cnt;
    queue_enable_i = 1'b0;
    tick(4);
    clear_n_i = 1'b0;
    tick(4);
    clear_n_i = 1'b1;
    tick(8);
    check("clear", clr_cnt - c, 32'h1);
    c = wr_cnt;
    reg_ready_i = 1'b0;
    pwrite(3);
    reg_ready_i = 1'b1;
    tick(30);
    check("one_entry", wr_cnt - c, 32'h1);
  endtask : t_clear

  initial begin
    t_reset();
    t_serial();
    t_frames();
    t_readback();
    t_chain();
    t_fill();
    t_clear();
    t_i2c();
    summarize();
  end
endmodule : dac_host_serial_interface_test
